// >>> src/act_ctrl1.sv
// What this block does
// - bit0 write resets device and both registers
// - soft reset clears FIFO pointer and offset
// - five conversion results after reset dropped before first store
// - read bit1 shows FIFO overflow occurred
// - overflow flag clears after register is read
// - bit1 write clears the FIFO
// - fill reaching threshold asserts samples ready
// - bit4 selects level or pulse, resets one
// - bit5 selects polarity, high when one
// - bit6 makes write strobe a direction input
// - combined mode: high reads, low writes
// - bit6 clear uses separate read, write strobes
// - bit7 selects twos complement or straight binary
// - bit8 starts zero-input offset calibration conversion
// - stored offset subtracted from later results
// - bit9 debug: reads return CR0 then CR1
// - threshold table depends on channel count
// - differential or single-ended input counts one
// - level drops on first read, rearms after threshold
// - pulse lasts half a conversion clock
// - no new pulse before threshold reads done
`timescale 1ns/1ns
`default_nettype none

module act_ctrl1 #(
	parameter int DATA_W = act_pkg::DATA_W,
	parameter int FIFO_DEPTH = act_pkg::FIFO_DEPTH,
	parameter int FIFO_AW = act_pkg::FIFO_AW
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// processor bus pins
	input wire logic cs0_n,
	input wire logic cs1,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic [DATA_W-1:0] data_in,
	output logic [DATA_W-1:0] data_out,
	output logic data_oe,
	// conversion side
	input wire logic ext_conversion_clock,
	input wire logic conv_valid,
	input wire logic [DATA_W-1:0] conv_data,
	output logic cal_force_zero,
	output logic [act_pkg::CR_W-1:0] input_config,
	// samples ready pin
	output logic samples_ready_out
);

	localparam logic [2:0] FLUSH_DONE = 3'(act_pkg::STARTUP_FLUSH);

	// channels minus one from the first register's input selection
	function automatic logic [1:0] chan_index(input logic [4:0] sel);
		unique case (sel)
			5'h11, 5'h15, 5'h19: chan_index = 2'h1;
			5'h12, 5'h16: chan_index = 2'h2;
			5'h13: chan_index = 2'h3;
			default: chan_index = 2'h0;
		endcase
	endfunction

	// synchronisers: three stages, a change counts once stages two and three agree
	act_pkg::act_pins_type pin_s1_r, pin_s2_r, pin_s3_r, pin_r;
	logic [DATA_W-1:0] din_s1_r, din_s2_r, din_s3_r;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pin_s1_r <= act_pkg::PINS_IDLE;
			pin_s2_r <= act_pkg::PINS_IDLE;
			pin_s3_r <= act_pkg::PINS_IDLE;
			pin_r <= act_pkg::PINS_IDLE;
		end else begin
			pin_s1_r <= {cs0_n, cs1, rd_n, wr_n, ext_conversion_clock};
			pin_s2_r <= pin_s1_r;
			pin_s3_r <= pin_s2_r;
			pin_r <= (pin_s2_r & pin_s3_r) | (pin_r & (pin_s2_r ^ pin_s3_r));
		end
	end

	// data pins only matter under a settled strobe, so they just follow the same depth
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			din_s1_r <= '0;
			din_s2_r <= '0;
			din_s3_r <= '0;
		end else begin
			din_s1_r <= data_in;
			din_s2_r <= din_s1_r;
			din_s3_r <= din_s2_r;
		end
	end

	// registers and state
	logic [act_pkg::CR_W-1:0] cr0_r;
	act_pkg::act_ctrl1_type cr1_r;
	logic rd_act_d_r, wr_act_d_r, cclk_d_r;
	logic [FIFO_AW-1:0] wr_ptr_r, rd_ptr_r;
	logic [act_pkg::FILL_W-1:0] fill_r, reads_left_r;
	logic [2:0] flush_cnt_r;
	logic [DATA_W-1:0] offset_r, data_out_r;
	act_pkg::act_rb_type rb_r;
	act_pkg::act_da_type da_r, da_nxt;
	logic out_pin_r;
	logic [DATA_W-1:0] mem_rdata;

	// strobe decode
	wire cs_act = !pin_r.cs0_n && pin_r.cs1;
	wire rd_act = cr1_r.rw_combined ? (cs_act && pin_r.wr_n)
		: (cs_act && !pin_r.rd_n && pin_r.wr_n);
	wire wr_act = cr1_r.rw_combined ? (cs_act && !pin_r.wr_n)
		: (cs_act && !pin_r.wr_n && pin_r.rd_n);
	wire rd_start = rd_act && !rd_act_d_r;
	wire wr_start = wr_act && !wr_act_d_r;
	wire [act_pkg::SEL_W-1:0] wsel = din_s3_r[DATA_W-1 -: act_pkg::SEL_W];
	wire wr_cr0 = wr_start && (wsel == act_pkg::SEL_CR0);
	wire wr_cr1 = wr_start && (wsel == act_pkg::SEL_CR1);
	act_pkg::act_ctrl1_type wcr1;
	assign wcr1 = din_s3_r[act_pkg::CR_W-1:0];
	wire soft_rst = wr_cr1 && wcr1.soft_reset;
	wire fifo_clr = soft_rst || (wr_cr1 && wcr1.fifo_overrun_flag);

	// conversion path
	wire flushed = (flush_cnt_r == FLUSH_DONE);
	wire conv_take = conv_valid && flushed && !fifo_clr;
	wire cal_take = conv_take && cr1_r.offset_cal;
	wire full = (fill_r == act_pkg::FILL_W'(FIFO_DEPTH));
	wire push = conv_take && !cr1_r.offset_cal && !full;
	wire overrun = conv_take && !cr1_r.offset_cal && full;
	wire [DATA_W-1:0] corrected = conv_data - offset_r;
	wire [DATA_W-1:0] stored = cr1_r.output_format_sel ? {~corrected[DATA_W-1], corrected[DATA_W-2:0]}
		: corrected;

	// read path
	wire rb_read = rd_start && cr1_r.config_readback_debug && (rb_r != act_pkg::RB_FIFO);
	wire pop = rd_start && !rb_read && (fill_r != '0) && !fifo_clr;
	wire rd_cr1 = rb_read && (rb_r == act_pkg::RB_CR1);

	// trigger threshold
	wire [1:0] nch = chan_index(cr0_r[7:3]);
	wire [1:0] tcode = {cr1_r.trigger_level_sel_hi, cr1_r.trigger_level_sel_lo};
	wire [act_pkg::FILL_W-1:0] fill_threshold_count = act_pkg::TRIG_TBL[nch][tcode];
	wire trig_hit = (fill_r >= fill_threshold_count);
	wire cclk_fall = cclk_d_r && !pin_r.ext_conversion_clock;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rd_act_d_r <= 1'b0;
			wr_act_d_r <= 1'b0;
			cclk_d_r <= 1'b0;
		end else begin
			rd_act_d_r <= rd_act;
			wr_act_d_r <= wr_act;
			cclk_d_r <= pin_r.ext_conversion_clock;
		end
	end

	// control registers
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cr0_r <= act_pkg::CR0_RESET;
			cr1_r <= act_pkg::CR1_RESET;
		end else if (soft_rst) begin
			cr0_r <= act_pkg::CR0_RESET;
			cr1_r <= act_pkg::CR1_RESET;
		end else begin
			if (wr_cr0) begin
				cr0_r <= din_s3_r[act_pkg::CR_W-1:0];
			end
			if (wr_cr1) begin
				cr1_r <= wcr1;
				cr1_r.soft_reset <= 1'b0;
				cr1_r.offset_cal <= wcr1.offset_cal || (cr1_r.offset_cal && !cal_take);
			end else if (cal_take) begin
				cr1_r.offset_cal <= 1'b0;
			end
			// overflow: set beats the read-back clear
			if (overrun) begin
				cr1_r.fifo_overrun_flag <= 1'b1;
			end else if (rd_cr1 || wr_cr1) begin
				cr1_r.fifo_overrun_flag <= 1'b0;
			end
		end
	end

	// flush counter, offset store
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			flush_cnt_r <= '0;
			offset_r <= '0;
		end else if (soft_rst) begin
			flush_cnt_r <= '0;
			offset_r <= '0;
		end else begin
			if (conv_valid && !flushed) begin
				flush_cnt_r <= flush_cnt_r + 3'h1;
			end
			if (cal_take) begin
				offset_r <= conv_data;
			end
		end
	end

	// FIFO pointers and fill
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			fill_r <= '0;
		end else if (fifo_clr) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			fill_r <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + FIFO_AW'(1);
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + FIFO_AW'(1);
			end
			fill_r <= fill_r + act_pkg::FILL_W'(push) - act_pkg::FILL_W'(pop);
		end
	end

	act_fifo_mem #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH),
		.AW(FIFO_AW)
	) u_mem (
		.mclk(mclk),
		.rst(rst),
		.we(push),
		.waddr(wr_ptr_r),
		.wdata(stored),
		.raddr(rd_ptr_r),
		.rdata(mem_rdata)
	);

	// read data and debug read-back sequence
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rb_r <= act_pkg::RB_CR0;
			data_out_r <= '0;
		end else begin
			if (wr_cr1 && wcr1.config_readback_debug) begin
				rb_r <= act_pkg::RB_CR0;
			end else if (rb_read) begin
				rb_r <= (rb_r == act_pkg::RB_CR0) ? act_pkg::RB_CR1 : act_pkg::RB_FIFO;
			end
			if (rb_read) begin
				data_out_r <= (rb_r == act_pkg::RB_CR0) ? {act_pkg::SEL_CR0, cr0_r}
					: {act_pkg::SEL_CR1, cr1_r};
			end else if (rd_start) begin
				data_out_r <= mem_rdata;
			end
		end
	end

	// samples ready sequencing
	always_comb begin
		da_nxt = da_r;
		unique case (da_r)
			act_pkg::DA_ARMED: begin
				if (trig_hit) begin
					da_nxt = act_pkg::DA_ACTIVE;
				end
			end
			act_pkg::DA_ACTIVE: begin
				if (cr1_r.da_pulse ? cclk_fall : pop) begin
					da_nxt = act_pkg::DA_DRAIN;
				end
			end
			act_pkg::DA_DRAIN: begin
				if (reads_left_r == '0) begin
					da_nxt = act_pkg::DA_ARMED;
				end
			end
		endcase
		if (fifo_clr) begin
			da_nxt = act_pkg::DA_ARMED;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			da_r <= act_pkg::DA_ARMED;
			reads_left_r <= '0;
			out_pin_r <= 1'b0;
		end else begin
			da_r <= da_nxt;
			if (fifo_clr) begin
				reads_left_r <= '0;
			end else if (da_r == act_pkg::DA_ARMED && trig_hit) begin
				reads_left_r <= fill_threshold_count;
			end else if (pop && reads_left_r != '0) begin
				reads_left_r <= reads_left_r - act_pkg::FILL_W'(1);
			end
			out_pin_r <= (da_nxt == act_pkg::DA_ACTIVE) ~^ cr1_r.da_polarity;
		end
	end

	// outputs
	assign data_out = data_out_r;
	assign data_oe = rd_act;
	assign cal_force_zero = cr1_r.offset_cal;
	assign input_config = cr0_r;
	assign samples_ready_out = out_pin_r;

	// checks
	sequence soft_rst_seq;
		soft_rst ##1 (cr1_r == act_pkg::CR1_RESET);
	endsequence

	sequence store_cleared_seq;
		(fill_r == '0) && (offset_r == '0) && (flush_cnt_r == '0);
	endsequence

	AST_SOFT_RESET: assert property (@(posedge mclk) disable iff (rst)
		soft_rst |-> soft_rst_seq and (##1 store_cleared_seq))
		else $error("soft reset left state behind");

	AST_FLUSH: assert property (@(posedge mclk) disable iff (rst)
		push |-> (flush_cnt_r == 3'h5))
		else $error("value stored before flush done");

	AST_OVF_SET: assert property (@(posedge mclk) disable iff (rst)
		(conv_valid && flushed && full && !cr1_r.offset_cal && !wr_cr1 && !soft_rst)
		|=> cr1_r.fifo_overrun_flag)
		else $error("overflow not flagged");

	AST_OVF_CLR: assert property (@(posedge mclk) disable iff (rst)
		(rd_cr1 && !overrun) |=> !cr1_r.fifo_overrun_flag)
		else $error("overflow flag survived read");

	AST_FIFO_CLR: assert property (@(posedge mclk) disable iff (rst)
		(wr_cr1 && wcr1.fifo_overrun_flag) |=> (fill_r == '0) && !cr1_r.soft_reset)
		else $error("fifo clear failed");

	AST_LEVEL_DROP: assert property (@(posedge mclk) disable iff (rst)
		(da_r == act_pkg::DA_ACTIVE && !cr1_r.da_pulse && pop) |=> (da_r == act_pkg::DA_DRAIN))
		else $error("level not dropped on read");

	AST_PULSE_END: assert property (@(posedge mclk) disable iff (rst)
		(da_r == act_pkg::DA_ACTIVE && cr1_r.da_pulse && cclk_fall && !fifo_clr)
		|=> (da_r == act_pkg::DA_DRAIN))
		else $error("pulse outlived half clock");

	AST_NO_REARM: assert property (@(posedge mclk) disable iff (rst)
		(da_r == act_pkg::DA_DRAIN && reads_left_r != '0) |=> (da_r != act_pkg::DA_ACTIVE))
		else $error("rearmed before reads done");

	AST_TRIGGER: assert property (@(posedge mclk) disable iff (rst)
		(da_r == act_pkg::DA_ARMED && fill_r >= fill_threshold_count && !fifo_clr)
		|=> (da_r == act_pkg::DA_ACTIVE))
		else $error("threshold reached without activation");

	AST_PIN_LEVEL: assert property (@(posedge mclk) disable iff (rst)
		(da_r == act_pkg::DA_ACTIVE && $stable(cr1_r.da_polarity))
		|-> (samples_ready_out == cr1_r.da_polarity))
		else $error("samples ready polarity wrong");

	AST_COMBINED: assert property (@(posedge mclk) disable iff (rst)
		(cr1_r.rw_combined && rd_act) |-> (pin_r.wr_n && !wr_act))
		else $error("combined strobe misdecoded");

endmodule

`default_nettype wire

// >>> src/act_pkg.sv
package act_pkg;

	// converter word and register widths
	localparam int DATA_W = 12;
	localparam int CR_W = 10;
	localparam int SEL_W = 2;

	// on-chip sample store
	localparam int FIFO_DEPTH = 16;
	localparam int FIFO_AW = 4;
	localparam int FILL_W = 5;

	// pipeline results dropped after any reset before the first store
	localparam int STARTUP_FLUSH = 5;

	// register select code in bits 11:10 of a written word
	localparam logic [SEL_W-1:0] SEL_CR0 = 2'h0;
	localparam logic [SEL_W-1:0] SEL_CR1 = 2'h1;

	// reset values of both control registers
	localparam logic [CR_W-1:0] CR0_RESET = 10'h000;
	localparam logic [CR_W-1:0] CR1_RESET = 10'h030;

	// second control register layout, bit 9 down to bit 0
	typedef struct packed {
		logic config_readback_debug;
		logic offset_cal;
		logic output_format_sel;
		logic rw_combined;
		logic da_polarity;
		logic da_pulse;
		logic trigger_level_sel_hi;
		logic trigger_level_sel_lo;
		logic fifo_overrun_flag;
		logic soft_reset;
	} act_ctrl1_type;

	// bus and clock pins as seen after the synchronisers
	typedef struct packed {
		logic cs0_n;
		logic cs1;
		logic rd_n;
		logic wr_n;
		logic ext_conversion_clock;
	} act_pins_type;

	localparam act_pins_type PINS_IDLE = 5'h16;

	// fill threshold per [channels-1][trigger code]; last entry is the reserved code
	localparam logic [FILL_W-1:0] TRIG_TBL [0:3][0:3] = '{
		'{5'h01, 5'h04, 5'h08, 5'h0e},
		'{5'h02, 5'h04, 5'h08, 5'h0c},
		'{5'h03, 5'h06, 5'h09, 5'h0c},
		'{5'h04, 5'h08, 5'h0c, 5'h10}
	};

	// which register a debug read returns
	typedef enum logic [1:0] {RB_CR0, RB_CR1, RB_FIFO} act_rb_type;

	// samples_ready_out sequencing
	typedef enum logic [1:0] {DA_ARMED, DA_ACTIVE, DA_DRAIN} act_da_type;

endpackage

// >>> src/act_fifo_mem.sv
`timescale 1ns/1ns
`default_nettype none

module act_fifo_mem #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 16,
	parameter int AW = 4
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// write side
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [WIDTH-1:0] wdata,
	// read side, data one cycle after the address
	input wire logic [AW-1:0] raddr,
	output logic [WIDTH-1:0] rdata
);

	logic [WIDTH-1:0] mem [0:DEPTH-1];

	always_ff @(posedge mclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rdata <= '0;
		end else begin
			rdata <= mem[raddr];
		end
	end

endmodule

`default_nettype wire

// >>> bench/act_host_model.sv
`timescale 1ns/1ns
`default_nettype none

module act_host_model (
	// clock
	input wire logic mclk,
	// processor pins
	output logic cs0_n,
	output logic cs1,
	output logic rd_n,
	output logic wr_n,
	output logic [11:0] data_in,
	// read data
	input wire logic [11:0] data_out,
	input wire logic data_oe
);
	bit comb = 1'b0;
	logic oe_seen = 1'b0;

	initial begin
		cs0_n = 1'b1;
		cs1 = 1'b0;
		rd_n = 1'b1;
		wr_n = 1'b1;
		data_in = 12'h000;
	end

	// direction lines settle one cycle before select and are held two cycles after it
	task automatic access(input bit rd, input logic [11:0] w, output logic [11:0] r);
		@(posedge mclk);
		#1;
		wr_n = rd;
		// combined mode holds the read strobe low to prove it is ignored
		rd_n = comb ? 1'b0 : !rd;
		data_in = rd ? ~data_in : w;
		@(posedge mclk);
		#1;
		cs0_n = 1'b0;
		cs1 = 1'b1;
		repeat (8) @(posedge mclk);
		r = data_out;
		oe_seen = data_oe;
		#1;
		cs0_n = 1'b1;
		cs1 = 1'b0;
		repeat (2) @(posedge mclk);
		#1;
		rd_n = 1'b1;
		wr_n = 1'b1;
		data_in = ~data_in;
		repeat (5) @(posedge mclk);
	endtask
endmodule

`default_nettype wire

// >>> bench/act_ctrl1_test.sv
`timescale 1ns/1ns
`default_nettype none

module act_ctrl1_test;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic conv_valid = 1'b0;
	logic ext = 1'b0;
	logic [11:0] conv_data = 12'h000;
	logic cs0_n, cs1, rd_n, wr_n, cal_force_zero, samples_ready_out, data_oe;
	logic [11:0] data_in, data_out, r;
	logic [9:0] input_config;
	int n_errors = 0;
	int cmp_count = 0;
	int q[$];
	int ofs, drop;
	int fill_threshold_count[4] = '{1, 4, 8, 14};
	bit fmt, cal, pol;

	always #5 mclk = ~mclk;

	act_ctrl1 DUT (.mclk(mclk), .rst(rst), .cs0_n(cs0_n), .cs1(cs1), .rd_n(rd_n), .wr_n(wr_n),
		.data_in(data_in), .data_out(data_out), .data_oe(data_oe), .ext_conversion_clock(ext),
		.conv_valid(conv_valid), .conv_data(conv_data), .cal_force_zero(cal_force_zero),
		.input_config(input_config), .samples_ready_out(samples_ready_out));

	act_host_model host (.mclk(mclk), .cs0_n(cs0_n), .cs1(cs1), .rd_n(rd_n), .wr_n(wr_n),
		.data_in(data_in), .data_out(data_out), .data_oe(data_oe));

	task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wrap_up();
		if (n_errors == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic mreset();
		q.delete();
		ofs = 0;
		drop = 5;
		fmt = 1'b0;
		cal = 1'b0;
	endtask

	task automatic wcr1(input logic [9:0] v);
		host.access(1'b0, {2'h1, v}, r);
		chk("write enable", 12'(host.oe_seen), 12'h000);
		if (v[0])
			mreset();
		if (v[1])
			q.delete();
		fmt = v[7];
		cal = v[8];
	endtask

	// model keeps only what the store would hold; overflowing results are lost
	task automatic conv(input int n);
		repeat (n) begin
			@(posedge mclk);
			#1;
			conv_valid = 1'b1;
			conv_data = 12'($urandom);
			if (drop > 0)
				drop--;
			else if (cal) begin
				ofs = conv_data;
				cal = 1'b0;
			end else if (q.size() < 16)
				q.push_back((conv_data - ofs) ^ (fmt ? 'h800 : 0));
			@(posedge mclk);
			#1;
			conv_valid = 1'b0;
		end
	endtask

	task automatic rdq(input int n);
		repeat (n) begin
			host.access(1'b1, 12'h000, r);
			chk("fifo word", r, 12'(q.pop_front()));
			chk("read enable", 12'(host.oe_seen), 12'h001);
		end
	endtask

	task automatic pin(input bit act);
		// filtered pins lag four edges behind the far side
		repeat (6) @(posedge mclk);
		chk("samples ready", 12'(samples_ready_out), 12'(act ^ !pol));
	endtask

	initial begin
		#200000;
		n_errors++;
		wrap_up();
	end

	initial begin
		void'($urandom(6130));
		repeat (5) @(posedge mclk);
		#1;
		rst = 1'b0;
		mreset();
		pol = 1'b1;
		// debug read-back while an overflow is pending
		host.access(1'b0, 12'h008, r);
		wcr1(10'h230);
		conv(22);
		host.access(1'b1, 12'h000, r);
		chk("cr0 readback", r, 12'h008);
		host.access(1'b1, 12'h000, r);
		chk("cr1 readback", r, 12'h632);
		rdq(16);
		wcr1(10'h001);
		wcr1(10'h200);
		host.access(1'b1, 12'h000, r);
		chk("cr0 after reset", r, 12'h000);
		chk("input config", 12'(input_config), 12'h000);
		host.access(1'b1, 12'h000, r);
		chk("cr1 after reset", r, 12'h600);
		// every trigger code at one channel, random polarity and format
		for (int c = 0; c < 4; c++) begin
			pol = 1'($urandom);
			wcr1(10'h001);
			wcr1({2'h0, 1'($urandom), 1'b0, pol, 1'b0, 2'(c), 2'h0});
			conv(5 + fill_threshold_count[c] - 1);
			pin(1'b0);
			conv(1);
			pin(1'b1);
			rdq(1);
			pin(1'b0);
			rdq(fill_threshold_count[c] - 1);
		end
		pol = 1'b1;
		wcr1(10'h024);
		conv(3);
		wcr1(10'h026);
		conv(1);
		pin(1'b0);
		conv(3);
		pin(1'b1);
		rdq(4);
		// calibration with straight binary output
		wcr1(10'h1a4);
		chk("cal force", 12'(cal_force_zero), 12'h001);
		conv(1);
		repeat (2) @(posedge mclk);
		chk("cal force", 12'(cal_force_zero), 12'h000);
		conv(4);
		rdq(4);
		// pulse style ends on a falling conversion clock
		wcr1(10'h001);
		conv(6);
		pin(1'b1);
		#1;
		ext = 1'b1;
		repeat (8) @(posedge mclk);
		#1;
		ext = 1'b0;
		pin(1'b0);
		rdq(1);
		// combined direction strobe
		wcr1(10'h064);
		host.comb = 1'b1;
		conv(2);
		rdq(2);
		wcr1(10'h001);
		host.comb = 1'b0;
		conv(6);
		pin(1'b1);
		// three scanned inputs raise the threshold
		wcr1(10'h001);
		host.access(1'b0, 12'h090, r);
		chk("input config", 12'(input_config), 12'h090);
		wcr1(10'h024);
		conv(10);
		pin(1'b0);
		conv(1);
		pin(1'b1);
		rdq(6);
		wrap_up();
	end
endmodule

`default_nettype wire
